// ### bench/cpu_branch_jump_unit_tb.sv
// bench for the jump group unit running a small program
`timescale 1ns/1ps
module cpu_branch_jump_unit_tb;
	logic        i_clock = 1'b0;
	logic        i_sys_rst = 1'b1;
	logic        zero = 1'b0;
	logic        m1, pm, mem_rd, unsup;
	logic [15:0] mem_addr, pa, pc;
	logic [7:0]  mem_data, flags, b_reg;
	int          fails = 0;
	int          compares = 0;
	logic [31:0] prog [9] = '{32'h00002803, 32'h0003e900, 32'h0005287f,
		32'h000720fa, 32'h0100207f, 32'h0102dde9, 32'h0200fde9,
		32'h0300107f, 32'h038110fe};
	always #25 i_clock = ~i_clock;
	always @(negedge i_clock)
	begin
		pm <= m1 && !i_sys_rst;
		pa <= mem_addr;
	end
	prog_mem u_prog_mem (.i_clock(i_clock), .i_addr(mem_addr),
		.i_rd(mem_rd), .o_data(mem_data));
	cpu_branch_jump_unit u_cpu_branch_jump_unit (.i_clock(i_clock),
		.i_sys_rst(i_sys_rst), .i_mem_data(mem_data), .o_mem_addr(mem_addr),
		.o_mem_rd(mem_rd), .i_zero_flag(zero), .i_pointer_pair(16'h0100),
		.i_first_index_reg(16'h0200), .i_second_index_reg(16'h0300),
		.i_flags(8'ha5), .o_flags(flags), .o_b_reg(b_reg), .o_pc(pc),
		.o_m1(m1), .o_unsupported(unsup));
	task final_report;
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(input string n, input logic [15:0] e, s);
		compares++;
		if (s !== e)
		begin
			fails++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask
	// a fetch starts when m1 rises or moves to a new address
	task automatic step(input logic [15:0] a, input int n, input logic z);
		int c;
		c = 0;
		do
		begin
			@(negedge i_clock);
			c++;
			if (c > 300)
			begin
				fails++;
				final_report;
			end
		end while (!(m1 === 1'b1 && (pm !== 1'b1 || mem_addr !== pa)));
		chk("fetch address", a, mem_addr);
		chk("pc", a, pc);
		chk("unsupported", 16'h0000, {15'h0000, unsup});
		if (n > 0) chk("states", n[15:0], c[15:0]);
		chk("flags", 16'h00a5, {8'h00, flags});
		@(posedge i_clock);
		zero <= z;
	endtask
	task relative_jumps;
		step(16'h0000, 0, 1'b1);
		step(16'h0005, 12, 1'b0);
		step(16'h0007, 7, 1'b0);
		step(16'h0003, 12, 1'b1);
	endtask
	task pair_jumps;
		step(16'h0100, 4, 1'b1);
		step(16'h0102, 7, 1'b0);
		step(16'h0103, 4, 1'b0);
		step(16'h0200, 4, 1'b0);
		step(16'h0201, 4, 1'b0);
		step(16'h0300, 4, 1'b0);
	endtask
	task b_loop;
		step(16'h0381, 13, 1'b0);
		repeat (254) step(16'h0381, 13, 1'b0);
		step(16'h0383, 8, 1'b0);
		chk("b register", 16'h0000, {8'h00, b_reg});
	endtask
	initial
	begin
		repeat (6) @(posedge i_clock);
		foreach (prog[i])
		begin
			u_prog_mem.mem[prog[i][31:16]] = prog[i][15:8];
			u_prog_mem.mem[prog[i][31:16] + 16'h1] = prog[i][7:0];
		end
		i_sys_rst <= 1'b0;
		relative_jumps;
		pair_jumps;
		b_loop;
		final_report;
	end
endmodule // cpu_branch_jump_unit_tb

// ### bench/prog_mem.sv
// program memory model feeding opcode and displacement bytes
`timescale 1ns/1ps
module prog_mem
(
	// clock
	input  wire logic        i_clock,
	// fetch side
	input  wire logic [15:0] i_addr,
	input  wire logic        i_rd,
	output logic      [7:0]  o_data
);
	logic [7:0] mem [65536];
	logic [7:0] last_ff;
	initial foreach (mem[i]) mem[i] = 8'h00;
	always_ff @(posedge i_clock) if (i_rd) last_ff <= mem[i_addr];
	// idle bus shows the inverse so a stale byte never passes as valid
	assign o_data = i_rd ? mem[i_addr] : ~last_ff;
endmodule // prog_mem

// ### pkg/branch_jump_pkg.sv
// constants for the branch and jump execution unit
package branch_jump_pkg;
	localparam logic [7:0] OP_JR_Z     = 8'h28;
	localparam logic [7:0] OP_JR_NZ    = 8'h20;
	localparam logic [7:0] OP_LOOP_B   = 8'h10;
	localparam logic [7:0] OP_JP_PAIR  = 8'he9;
	localparam logic [7:0] PFX_FIRST   = 8'hdd;
	localparam logic [7:0] PFX_SECOND  = 8'hfd;
	// T-state lengths of each machine cycle
	localparam logic [2:0] T_FETCH     = 3'h4;
	localparam logic [2:0] T_FETCH_B   = 3'h5;
	localparam logic [2:0] T_READ      = 3'h3;
	localparam logic [2:0] T_ADD       = 3'h5;
	localparam logic [2:0] T_PREFIX    = 3'h4;
	localparam logic [15:0] PC_RESET   = 16'h0000;
	localparam logic [7:0] B_RESET     = 8'h00;

	typedef enum logic [2:0] {
		ST_FETCH  = 3'b000,
		ST_OPX    = 3'b001,
		ST_DISP   = 3'b010,
		ST_ADD    = 3'b011,
		ST_PFX    = 3'b100
	} bj_state_t;
endpackage

// ### src/cpu_branch_jump_unit.sv
// jump group executor: conditional relative jumps, pair jumps, b-loop
`timescale 1ns/1ps
module cpu_branch_jump_unit
	import branch_jump_pkg::*;
(
	// clock and reset
	input  wire logic        i_clock,
	input  wire logic        i_sys_rst,
	// program memory
	input  wire logic [7:0]  i_mem_data,
	output logic      [15:0] o_mem_addr,
	output logic             o_mem_rd,
	// register file and flags
	input  wire logic        i_zero_flag,
	input  wire logic [15:0] i_pointer_pair,
	input  wire logic [15:0] i_first_index_reg,
	input  wire logic [15:0] i_second_index_reg,
	input  wire logic [7:0]  i_flags,
	output logic      [7:0]  o_flags,
	output logic      [7:0]  o_b_reg,
	output logic      [15:0] o_pc,
	// status
	output logic             o_m1,
	output logic             o_unsupported
);
	import branch_jump_pkg::*;

	// machine-cycle sequencing
	bj_state_t   state_ff;
	bj_state_t   nxt_state;
	logic [2:0]  tcnt_ff;
	logic [2:0]  tlen_ff;
	logic [2:0]  nxt_tlen;
	logic        last_t;
	logic        in_m1;
	// state kept by this unit
	logic [15:0] pc_ff;
	logic [7:0]  b_ff;
	logic [7:0]  flags_ff;
	// instruction in flight
	logic [7:0]  op_ff;
	logic [15:0] op_addr_ff;
	logic [1:0]  pfx_ff;
	logic [7:0]  disp_ff;
	logic        unsup_ff;
	logic [4:0]  icnt_ff;
	// decode of the byte on the bus, then branch condition and target
	logic        is_pfx_byte;
	logic        is_pair_jump;
	logic        is_rel_jump;
	logic        is_b_loop;
	logic        take;
	logic [15:0] disp_ext;
	logic [15:0] target;

	assign last_t       = (tcnt_ff == tlen_ff - 3'h1);
	assign in_m1        = (state_ff == ST_FETCH) || (state_ff == ST_PFX);
	assign is_pfx_byte  = (i_mem_data == PFX_FIRST)
		|| (i_mem_data == PFX_SECOND);
	assign is_pair_jump = (i_mem_data == OP_JP_PAIR);
	// relative forms take no prefix; a prefixed one counts as unsupported
	assign is_rel_jump  = (state_ff == ST_FETCH)
		&& ((i_mem_data == OP_JR_Z) || (i_mem_data == OP_JR_NZ));
	assign is_b_loop    = (state_ff == ST_FETCH) && (i_mem_data == OP_LOOP_B);
	assign disp_ext     = {{8{disp_ff[7]}}, disp_ff};
	// pc already points past both bytes when the add cycle ends
	assign target       = pc_ff + disp_ext;

	// decided at the end of the displacement read; b is already decremented
	always_comb
	begin
		case (op_ff)
			OP_JR_Z:   take = i_zero_flag;
			OP_JR_NZ:  take = !i_zero_flag;
			OP_LOOP_B: take = (b_ff != 8'h00);
			default:   take = 1'b0;
		endcase
	end

	assign o_flags       = flags_ff;
	assign o_mem_addr    = pc_ff;
	assign o_mem_rd      = in_m1 || (state_ff == ST_DISP);
	assign o_m1          = in_m1;
	assign o_pc          = pc_ff;
	assign o_b_reg       = b_ff;
	assign o_unsupported = unsup_ff;

	// next machine cycle and its length in states
	always_comb
	begin
		nxt_state = state_ff;
		nxt_tlen  = tlen_ff;
		case (state_ff)
			ST_FETCH, ST_PFX:
			begin
				if (is_pfx_byte)
				begin
					nxt_state = ST_PFX;
					nxt_tlen  = T_PREFIX;
				end
				else if (is_rel_jump)
				begin
					nxt_state = ST_DISP;
					nxt_tlen  = T_READ;
				end
				else if (is_b_loop)
				begin
					// the loop opcode cycle runs one state longer
					nxt_state = ST_OPX;
					nxt_tlen  = T_FETCH_B - T_FETCH;
				end
				else
				begin
					nxt_state = ST_FETCH;
					nxt_tlen  = T_FETCH;
				end
			end
			ST_OPX:
			begin
				nxt_state = ST_DISP;
				nxt_tlen  = T_READ;
			end
			ST_DISP:
			begin
				if (take)
				begin
					nxt_state = ST_ADD;
					nxt_tlen  = T_ADD;
				end
				else
				begin
					nxt_state = ST_FETCH;
					nxt_tlen  = T_FETCH;
				end
			end
			default:
			begin
				nxt_state = ST_FETCH;
				nxt_tlen  = T_FETCH;
			end
		endcase
	end

	always_ff @(posedge i_clock)
	begin
		if (i_sys_rst)
		begin
			state_ff <= ST_FETCH;
			tcnt_ff  <= 3'h0;
			tlen_ff  <= T_FETCH;
		end
		else if (!last_t)
			tcnt_ff <= tcnt_ff + 3'h1;
		else
		begin
			tcnt_ff  <= 3'h0;
			state_ff <= nxt_state;
			tlen_ff  <= nxt_tlen;
		end
	end

	// states since the instruction began, prefix cycle included
	always_ff @(posedge i_clock)
	begin
		if (i_sys_rst)
			icnt_ff <= 5'h00;
		else if (last_t && nxt_state == ST_FETCH)
			icnt_ff <= 5'h00;
		else
			icnt_ff <= icnt_ff + 5'h01;
	end

	always_ff @(posedge i_clock)
	begin
		if (i_sys_rst)
			pc_ff <= PC_RESET;
		else if (last_t)
		begin
			case (state_ff)
				ST_FETCH, ST_PFX:
				begin
					if (is_pair_jump)
					begin
						case (pfx_ff)
							2'b01:   pc_ff <= i_first_index_reg;
							2'b10:   pc_ff <= i_second_index_reg;
							default: pc_ff <= i_pointer_pair;
						endcase
					end
					else
						pc_ff <= pc_ff + 16'h0001;
				end
				ST_DISP: pc_ff <= pc_ff + 16'h0001;
				ST_ADD:  pc_ff <= target;
				default: pc_ff <= pc_ff;
			endcase
		end
	end

	always_ff @(posedge i_clock)
	begin
		if (i_sys_rst)
		begin
			op_ff      <= 8'h00;
			op_addr_ff <= PC_RESET;
			pfx_ff     <= 2'b00;
		end
		else if (last_t && in_m1)
		begin
			op_ff      <= i_mem_data;
			op_addr_ff <= pc_ff;
			if (is_pfx_byte)
				pfx_ff <= (i_mem_data == PFX_FIRST) ? 2'b01 : 2'b10;
			else
				pfx_ff <= 2'b00;
		end
	end

	// stands for one machine cycle after an opcode nobody here handles
	always_ff @(posedge i_clock)
	begin
		if (i_sys_rst)
			unsup_ff <= 1'b0;
		else if (last_t)
			unsup_ff <= in_m1 && !(is_pfx_byte || is_pair_jump
				|| is_rel_jump || is_b_loop);
	end

	always_ff @(posedge i_clock)
	begin
		if (i_sys_rst)
			b_ff <= B_RESET;
		else if (last_t && state_ff == ST_OPX)
			b_ff <= b_ff - 8'h01;
	end

	always_ff @(posedge i_clock)
	begin
		if (i_sys_rst)
			disp_ff <= 8'h00;
		else if (last_t && state_ff == ST_DISP)
			disp_ff <= i_mem_data;
	end

	// no flag is computed here, so the flag register is only carried
	always_ff @(posedge i_clock)
	begin
		flags_ff <= i_flags;
	end

	rel_z_taken_a: assert property (
		@(posedge i_clock) disable iff (i_sys_rst)
		(state_ff == ST_DISP && last_t && op_ff == OP_JR_Z && i_zero_flag)
		|=> (state_ff == ST_ADD))
		else $error("zero-set jump skipped its add cycle");
	rel_z_fall_a: assert property (
		@(posedge i_clock) disable iff (i_sys_rst)
		(state_ff == ST_DISP && last_t && op_ff == OP_JR_Z && !i_zero_flag)
		|=> (state_ff == ST_FETCH && pc_ff == $past(pc_ff) + 16'h0001))
		else $error("zero-clear jump did not fall through");
	rel_nz_taken_a: assert property (
		@(posedge i_clock) disable iff (i_sys_rst)
		(state_ff == ST_DISP && last_t && op_ff == OP_JR_NZ && !i_zero_flag)
		|=> (state_ff == ST_ADD))
		else $error("not-zero jump skipped its add cycle");
	rel_nz_fall_a: assert property (
		@(posedge i_clock) disable iff (i_sys_rst)
		(state_ff == ST_DISP && last_t && op_ff == OP_JR_NZ && i_zero_flag)
		|=> (state_ff == ST_FETCH && pc_ff == $past(pc_ff) + 16'h0001))
		else $error("not-zero jump did not fall through");
	rel_range_a: assert property (
		@(posedge i_clock) disable iff (i_sys_rst)
		(state_ff == ST_ADD && last_t)
		|=> ($signed(pc_ff - op_addr_ff) >= -126
		&& $signed(pc_ff - op_addr_ff) <= 129))
		else $error("relative target outside its reach");
	rel_offset_a: assert property (
		@(posedge i_clock) disable iff (i_sys_rst)
		(state_ff == ST_ADD && last_t)
		|=> (pc_ff - op_addr_ff == {{8{disp_ff[7]}}, disp_ff} + 16'h0002))
		else $error("relative target not opcode address plus offset");
	jump_taken_len_a: assert property (
		@(posedge i_clock) disable iff (i_sys_rst)
		(state_ff == ST_ADD && last_t && op_ff != OP_LOOP_B)
		|-> (icnt_ff == 5'h0b))
		else $error("taken relative jump not twelve states");
	jump_fall_len_a: assert property (
		@(posedge i_clock) disable iff (i_sys_rst)
		(state_ff == ST_DISP && last_t && !take && op_ff != OP_LOOP_B)
		|-> (icnt_ff == 5'h06))
		else $error("untaken relative jump not seven states");
	pointer_jump_a: assert property (
		@(posedge i_clock) disable iff (i_sys_rst)
		(state_ff == ST_FETCH && last_t && is_pair_jump)
		|-> (icnt_ff == 5'h03) ##1 (pc_ff == $past(i_pointer_pair)))
		else $error("pointer pair jump wrong target or length");
	first_index_a: assert property (
		@(posedge i_clock) disable iff (i_sys_rst)
		(state_ff == ST_PFX && pfx_ff == 2'b01 && last_t && is_pair_jump)
		|-> (icnt_ff == 5'h07) ##1 (pc_ff == $past(i_first_index_reg)))
		else $error("first index jump wrong target or length");
	second_index_a: assert property (
		@(posedge i_clock) disable iff (i_sys_rst)
		(state_ff == ST_PFX && pfx_ff == 2'b10 && last_t && is_pair_jump)
		|-> (icnt_ff == 5'h07) ##1 (pc_ff == $past(i_second_index_reg)))
		else $error("second index jump wrong target or length");
	loop_taken_len_a: assert property (
		@(posedge i_clock) disable iff (i_sys_rst)
		(state_ff == ST_ADD && last_t && op_ff == OP_LOOP_B)
		|-> (icnt_ff == 5'h0c && b_ff != 8'h00))
		else $error("taken loop not thirteen states");
	loop_fall_len_a: assert property (
		@(posedge i_clock) disable iff (i_sys_rst)
		(state_ff == ST_DISP && last_t && !take && op_ff == OP_LOOP_B)
		|-> (icnt_ff == 5'h07 && b_ff == 8'h00))
		else $error("finished loop not eight states");
	flags_kept_a: assert property (
		@(posedge i_clock) disable iff (i_sys_rst)
		1'b1 |=> (o_flags == $past(i_flags)))
		else $error("flag register changed by a jump");

	zero_taken_c: cover property (@(posedge i_clock)
		state_ff == ST_ADD && last_t && op_ff == OP_JR_Z);
	notzero_taken_c: cover property (@(posedge i_clock)
		state_ff == ST_ADD && last_t && op_ff == OP_JR_NZ);
	index_jump_c: cover property (@(posedge i_clock)
		state_ff == ST_PFX && last_t && is_pair_jump);
	loop_done_c: cover property (@(posedge i_clock)
		state_ff == ST_DISP && last_t && !take && op_ff == OP_LOOP_B);
endmodule // cpu_branch_jump_unit
